// [verilog/dpr_pkg.sv]
// Package: constants and types for the discoverable parameter reader
package dpr_pkg;

    // ------------------------------------------------------------
    // Command and framing
    // ------------------------------------------------------------
    localparam logic [7:0] CMD_READ_TABLE = 8'h5A;
    localparam int ADDR_BYTES = 3;
    localparam int DUMMY_BYTES = 1;
    localparam logic [5:0] HDR_BITS = 6'd40;   // Opcode + address + dummy bits

    // ------------------------------------------------------------
    // Table contents
    // ------------------------------------------------------------
    localparam logic [7:0] SIG_B0 = 8'h53;
    localparam logic [7:0] SIG_B1 = 8'h46;
    localparam logic [7:0] SIG_B2 = 8'h44;
    localparam logic [7:0] SIG_B3 = 8'h50;
    localparam logic [7:0] FMT_MINOR = 8'h00;
    localparam logic [7:0] FMT_MAJOR = 8'h01;
    localparam logic [7:0] PARAMETER_HEADER_COUNT = 8'h00;
    localparam logic [7:0] HDR_ID = 8'h00;
    localparam logic [7:0] TBL_MINOR = 8'h00;
    localparam logic [7:0] TBL_MAJOR = 8'h01;
    localparam logic [7:0] TBL_LEN_WORDS = 8'h09;
    localparam logic [23:0] PARAMETER_TABLE_POINTER = 24'h00_0030;
    localparam logic [7:0] UNUSED_BYTE = 8'hFF;
    localparam logic [1:0] ERASE_GRAN_4K = 2'b01;
    localparam logic WRITE_GRAN = 1'b1;
    localparam logic [1:0] VSR_WREN_SEL = 2'b01;
    localparam logic [2:0] PARAM0_RSVD = 3'b111;
    localparam logic [7:0] ERASE_4K_OPCODE = 8'h20;

    // ------------------------------------------------------------
    // Table layout
    // ------------------------------------------------------------
    localparam int ADDR_W = 24;
    localparam logic [23:0] TABLE_LAST = 24'h00_00FF;  // Highest location, then wrap

    typedef enum logic [1:0] {
        DPR_IDLE,
        DPR_HEADER,
        DPR_DATA,
        DPR_IGNORE
    } dpr_state_t;

    // Link pins after synchronisation
    typedef struct packed {
        logic sel_n;
        logic sck;
        logic mosi;
    } dpr_link_t;

endpackage

// [verilog/dpr_table_rom.sv]
// Constant table of discoverable parameters, one byte per address
`timescale 1ns/1ns
module dpr_table_rom (
    // Lookup
    input wire logic [7:0] addr,
    output logic [7:0] data
);

    // ------------------------------------------------------------
    // Byte lookup
    // ------------------------------------------------------------
    // Decoded as a case so synthesis folds it into a few gates
    always_comb begin
        case (addr)
            8'h00: data = dpr_pkg::SIG_B0;
            8'h01: data = dpr_pkg::SIG_B1;
            8'h02: data = dpr_pkg::SIG_B2;
            8'h03: data = dpr_pkg::SIG_B3;
            8'h04: data = dpr_pkg::FMT_MINOR;
            8'h05: data = dpr_pkg::FMT_MAJOR;
            8'h06: data = dpr_pkg::PARAMETER_HEADER_COUNT;
            8'h07: data = dpr_pkg::UNUSED_BYTE;
            8'h08: data = dpr_pkg::HDR_ID;
            8'h09: data = dpr_pkg::TBL_MINOR;
            8'h0A: data = dpr_pkg::TBL_MAJOR;
            8'h0B: data = dpr_pkg::TBL_LEN_WORDS;
            8'h0C: data = dpr_pkg::PARAMETER_TABLE_POINTER[7:0];
            8'h0D: data = dpr_pkg::PARAMETER_TABLE_POINTER[15:8];
            8'h0E: data = dpr_pkg::PARAMETER_TABLE_POINTER[23:16];
            8'h0F: data = dpr_pkg::UNUSED_BYTE;
            8'h30: data = {dpr_pkg::PARAM0_RSVD, dpr_pkg::VSR_WREN_SEL,
                           dpr_pkg::WRITE_GRAN, dpr_pkg::ERASE_GRAN_4K};
            8'h31: data = dpr_pkg::ERASE_4K_OPCODE;
            default: data = dpr_pkg::UNUSED_BYTE;
        endcase
    end

endmodule

// [verilog/dpr_reader.sv]
// Serial read engine for the discoverable parameter table
`timescale 1ns/1ns
module dpr_reader (
    // Clock and reset
    input wire logic mclk,
    input wire logic rst,
    // Serial link pins
    input wire logic chip_select_n,
    input wire logic serial_clock,
    input wire logic serial_data_in,
    // Serial output pin, enable active low
    output logic serial_data_out,
    output logic serial_data_out_oe_n,
    // Status from the erase and program engine
    input wire logic write_busy,
    // Observation
    output logic read_active
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    dpr_pkg::dpr_link_t meta_reg;
    dpr_pkg::dpr_link_t sync_reg;
    logic sck_prev_reg;
    logic busy_meta_reg;
    logic busy_sync_reg;

    // Two flops on every pin; select idles high through reset
    always_ff @(posedge mclk) begin
        if (rst) begin
            meta_reg <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            sync_reg <= '{sel_n: 1'b1, sck: 1'b0, mosi: 1'b0};
            sck_prev_reg <= 1'b0;
        end else begin
            meta_reg <= '{sel_n: chip_select_n, sck: serial_clock, mosi: serial_data_in};
            sync_reg <= meta_reg;
            sck_prev_reg <= sync_reg.sck;
        end
    end

    // Busy status crosses in from the program engine as a level
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_meta_reg <= 1'b0;
            busy_sync_reg <= 1'b0;
        end else begin
            busy_meta_reg <= write_busy;
            busy_sync_reg <= busy_meta_reg;
        end
    end

    // ------------------------------------------------------------
    // Edge detection
    // ------------------------------------------------------------
    // The link clock is sampled, so it must stay below a quarter of mclk
    logic sck_rise;
    logic sck_fall;
    logic selected;

    assign sck_rise = sync_reg.sck & ~sck_prev_reg;
    assign sck_fall = ~sync_reg.sck & sck_prev_reg;
    assign selected = ~sync_reg.sel_n;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    dpr_pkg::dpr_state_t state_reg;
    dpr_pkg::dpr_state_t state_next;
    logic [5:0] bit_cnt_reg;
    logic [39:0] shift_in_reg;
    logic [2:0] out_bit_reg;
    logic [23:0] addr_reg;
    logic [7:0] out_byte_reg;
    logic drive_reg;
    logic [7:0] rom_data;
    logic [7:0] opcode_seen;

    // Opcode as it stands on its eighth rising edge: seven bits already in
    // the shift register plus the bit being sampled in this cycle
    assign opcode_seen = {shift_in_reg[6:0], sync_reg.mosi};

    // Sequence control; select high always returns to idle
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            dpr_pkg::DPR_IDLE: begin
                if (selected) begin
                    state_next = dpr_pkg::DPR_HEADER;
                end
            end
            dpr_pkg::DPR_HEADER: begin
                if (sck_rise && bit_cnt_reg == 6'd7 &&
                        (opcode_seen != dpr_pkg::CMD_READ_TABLE ||
                        busy_sync_reg)) begin
                    state_next = dpr_pkg::DPR_IGNORE;
                end else if (sck_rise && bit_cnt_reg == dpr_pkg::HDR_BITS - 6'd1) begin
                    state_next = dpr_pkg::DPR_DATA;
                end
            end
            dpr_pkg::DPR_DATA: begin
                state_next = dpr_pkg::DPR_DATA;
            end
            dpr_pkg::DPR_IGNORE: begin
                state_next = dpr_pkg::DPR_IGNORE;
            end
            default: begin
                state_next = dpr_pkg::DPR_IDLE;
            end
        endcase
        if (!selected) begin
            state_next = dpr_pkg::DPR_IDLE;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            state_reg <= dpr_pkg::DPR_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------
    // Header shift
    // ------------------------------------------------------------
    // MSB first: each rising edge pushes one bit in at the bottom
    always_ff @(posedge mclk) begin
        if (rst || state_reg == dpr_pkg::DPR_IDLE) begin
            bit_cnt_reg <= 6'd0;
            shift_in_reg <= '0;
        end else if (state_reg == dpr_pkg::DPR_HEADER && sck_rise) begin
            bit_cnt_reg <= bit_cnt_reg + 6'd1;
            shift_in_reg <= {shift_in_reg[38:0], sync_reg.mosi};
        end
    end

    // ------------------------------------------------------------
    // Table lookup
    // ------------------------------------------------------------
    dpr_table_rom u_rom (
        .addr(addr_reg[7:0]),
        .data(rom_data)
    );

    // ------------------------------------------------------------
    // Address and output shifting
    // ------------------------------------------------------------
    // The address is loaded at the end of the header; the byte at that
    // address is read from the table on the next falling edge and shifted out on falling edges
    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_reg <= '0;
            out_byte_reg <= dpr_pkg::UNUSED_BYTE;
            out_bit_reg <= 3'd0;
        end else if (state_reg == dpr_pkg::DPR_HEADER && state_next == dpr_pkg::DPR_DATA) begin
            // Address bytes sit above the dummy byte just finishing
            addr_reg <= shift_in_reg[30:7];
            out_bit_reg <= 3'd0;
        end else if (state_reg == dpr_pkg::DPR_DATA && sck_fall && selected) begin
            if (out_bit_reg == 3'd0) begin
                out_byte_reg <= {rom_data[6:0], 1'b0};
                if (addr_reg == dpr_pkg::TABLE_LAST) begin
                    addr_reg <= '0;
                end else begin
                    addr_reg <= addr_reg + 24'd1;
                end
            end else begin
                out_byte_reg <= {out_byte_reg[6:0], 1'b0};
            end
            out_bit_reg <= out_bit_reg + 3'd1;
        end
    end

    // Output bit: first bit of a byte comes straight from the table,
    // later bits from the shift register; both only move on falls
    logic dout_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            dout_reg <= 1'b1;
            drive_reg <= 1'b0;
        end else if (state_reg == dpr_pkg::DPR_DATA && selected) begin
            if (sck_fall) begin
                drive_reg <= 1'b1;
                dout_reg <= (out_bit_reg == 3'd0) ? rom_data[7] : out_byte_reg[7];
            end
        end else begin
            drive_reg <= 1'b0;
            dout_reg <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign serial_data_out = dout_reg;
    assign serial_data_out_oe_n = ~drive_reg;
    assign read_active = (state_reg == dpr_pkg::DPR_DATA);

endmodule

// [tb/dpr_reader_assertions.sv]
// Checker: link timing of the discoverable parameter reader
`timescale 1ns/1ns
module dpr_reader_checker (
    // Clock and reset
    input logic mclk,
    input logic rst,
    // Link pins
    input logic chip_select_n,
    input logic serial_clock,
    input logic serial_data_in,
    input logic serial_data_out,
    input logic serial_data_out_oe_n,
    // Status and observation
    input logic write_busy,
    input logic read_active
);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic sck_reg;
    logic [5:0] rise_reg;
    logic busy_frame_reg;
    // Raw rises per frame, so the header length is held to the exact count
    always_ff @(posedge mclk) begin
        sck_reg <= serial_clock;
        if (rst || chip_select_n) begin
            rise_reg <= 6'h00;
        end else if (serial_clock && !sck_reg && rise_reg != 6'h3F) begin
            rise_reg <= rise_reg + 6'h01;
        end
    end
    // Busy seen before select falls marks a frame that must stay silent
    always_ff @(posedge mclk) begin
        if (rst) begin
            busy_frame_reg <= 1'b0;
        end else if (chip_select_n) begin
            busy_frame_reg <= write_busy;
        end
    end
    sequence s_deselect;
        chip_select_n [*6];
    endsequence
    sequence s_hold_bit;
        $stable(serial_data_out) [*4];
    endsequence
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    a_idle_released: assert property (s_deselect |-> serial_data_out_oe_n && serial_data_out)
        else $error("output driven while deselected");
    a_active_drops: assert property ($rose(chip_select_n) |-> ##[1:6] !read_active)
        else $error("data phase outlived select");
    a_reset_quiet: assert property ($fell(rst) |-> serial_data_out_oe_n && !read_active)
        else $error("output active after reset");
    a_drive_start: assert property ($fell(serial_data_out_oe_n) |->
        rise_reg == 6'h28 && !serial_clock && !chip_select_n)
        else $error("drive began at wrong clock");
    a_active_start: assert property ($rose(read_active) |-> rise_reg == 6'h28)
        else $error("data phase began at wrong clock");
    a_out_on_fall: assert property (!serial_data_out_oe_n && !$past(serial_data_out_oe_n)
        && $changed(serial_data_out) |-> !$past(serial_clock, 2))
        else $error("output changed outside falling edge");
    a_hold_at_rise: assert property (!serial_data_out_oe_n && $rose(serial_clock) |=> s_hold_bit)
        else $error("output moved after rising edge");
    a_busy_silent: assert property (busy_frame_reg && !chip_select_n |-> serial_data_out_oe_n)
        else $error("read served during busy cycle");
endmodule
bind dpr_reader dpr_reader_checker u_checker (.mclk(mclk), .rst(rst),
    .chip_select_n(chip_select_n), .serial_clock(serial_clock),
    .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
    .serial_data_out_oe_n(serial_data_out_oe_n), .write_busy(write_busy),
    .read_active(read_active));

// [tb/dpr_host_model.sv]
// Host serial controller model for the table reader link
`timescale 1ns/1ns
module dpr_host_model (
    // Clock
    input logic mclk,
    // Link pins
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_data_in,
    input logic serial_data_out,
    input logic serial_data_out_oe_n
);
    // ----------------------------------------
    // Frame engine
    // ----------------------------------------
    localparam int HALF = 20;  // 160 ns link period
    logic [7:0] rx [0:15];
    logic drove;
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_data_in = 1'b0;
        drove = 1'b0;
    end
    // Idle data line toggles so a stale level never passes as valid
    always @(posedge mclk) begin
        if (chip_select_n) serial_data_in <= ~serial_data_in;
        if (!chip_select_n && !serial_data_out_oe_n) drove <= 1'b1;
    end
    // Header of 40 bits, then nbits of data sampled on each rise
    task automatic frame(input logic [39:0] hdr, input int nbits);
        @(posedge mclk);
        chip_select_n <= 1'b0;
        drove <= 1'b0;
        repeat (4) @(posedge mclk);
        for (int i = 0; i < 40 + nbits; i++) begin
            serial_data_in <= (i < 40) ? hdr[39 - i] : ~serial_data_in;
            repeat (HALF) @(posedge mclk);
            serial_clock <= 1'b1;
            if (i >= 40) rx[(i - 40) / 8][7 - (i - 40) % 8] = serial_data_out;
            repeat (HALF) @(posedge mclk);
            serial_clock <= 1'b0;
        end
        repeat (HALF) @(posedge mclk);
        chip_select_n <= 1'b1;
        repeat (8) @(posedge mclk);
    endtask
endmodule

// [tb/tb_top.sv]
// Self-checking bench for the discoverable parameter reader
`timescale 1ns/1ns
module tb_top;
    // ----------------------------------------
    // Harness
    // ----------------------------------------
    localparam logic [127:0] HEAD = 128'hFF00_0030_0901_0000_FF00_0100_5044_4653;
    logic mclk;
    logic rst;
    logic write_busy;
    logic [31:0] seed = 32'h4ad8_2bdd;
    int num_errors = 0;
    int comparisons = 0;
    wire chip_select_n, serial_clock, serial_data_in;
    wire serial_data_out, serial_data_out_oe_n, read_active;
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end
    dpr_reader u_dut (.mclk(mclk), .rst(rst), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n),
        .write_busy(write_busy), .read_active(read_active));
    dpr_host_model u_host (.mclk(mclk), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock), .serial_data_in(serial_data_in),
        .serial_data_out(serial_data_out), .serial_data_out_oe_n(serial_data_out_oe_n));
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Expected byte: header block, first parameter bytes, else blank
    function automatic logic [7:0] exp_byte(input logic [7:0] a);
        if (a < 8'h10) return HEAD[{a[3:0], 3'b000} +: 8];
        if (a == 8'h30) return {3'b111, 2'b01, 1'b1, 2'b01};
        return (a == 8'h31) ? 8'h20 : 8'hFF;
    endfunction
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One read frame, every byte compared, address wraps in 8 bits
    task automatic rd(input logic [23:0] start, input int n);
        u_host.frame({8'h5A, start, 8'h00}, n * 8);
        for (int i = 0; i < n; i++) begin
            check(u_host.rx[i], exp_byte(start[7:0] + 8'(i)));
        end
    endtask
    task automatic close_out();
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Watchdog sized well past the longest expected run
    initial begin
        repeat (90000) @(posedge mclk);
        num_errors++;
        close_out();
    end
    initial begin
        rst = 1'b1;
        write_busy = 1'b0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        repeat (8) @(posedge mclk);
        rd(24'h00_0000, 16);
        rd(24'h00_0030, 2);
        seed = xs(seed);
        rd({seed[23:8], 8'hFE}, 4);
        // Select raised in mid byte, then the line must be released
        u_host.frame({8'h5A, 24'h00_0000, 8'h00}, 13);
        check(u_host.rx[0], 8'h53);
        check({7'h00, serial_data_out_oe_n}, 8'h01);
        check({7'h00, read_active}, 8'h00);
        // Foreign opcode, then a read during a busy cycle: both silent
        u_host.frame({8'h03, 32'h0000_0000}, 16);
        check({7'h00, u_host.drove}, 8'h00);
        write_busy <= 1'b1;
        u_host.frame({8'h5A, 32'h0000_0000}, 16);
        check({7'h00, u_host.drove}, 8'h00);
        write_busy <= 1'b0;
        for (int k = 0; k < 8; k++) begin
            seed = xs(seed);
            rd(seed[23:0], 1 + int'(seed[26:24]));
        end
        close_out();
    end
endmodule
